// file: hdl/cksl_cnt.sv
`timescale 1ns/1ps
// down counter: load starts a run of val cycles with busy high
module cksl_cnt #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic clr,
  input wire logic [W-1:0] val,
  // state
  output logic [W-1:0] cnt,
  output logic busy
);

  logic [W-1:0] cnt_ff;
  logic busy_ff;
  logic [W-1:0] nxt_cnt;

  // clear wins over load so an early stop is never lost
  always_comb begin
    if (clr) begin
      nxt_cnt = '0;
    end else if (load) begin
      nxt_cnt = val;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // count and busy flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_cnt != '0);
    end
  end

  assign cnt = cnt_ff;
  assign busy = busy_ff;

endmodule

// file: hdl/cksl_div.sv
`timescale 1ns/1ps
// master clock divider, one tick per divided period
module cksl_div #(
  parameter int SW = 4,
  parameter int CW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requested ratio code
  input wire logic [SW-1:0] sel,
  // divided clock tick and the ratio code in use
  output logic tick,
  output logic [SW-1:0] act_sel
);

  logic [CW-1:0] cnt_ff;
  logic [SW-1:0] act_ff;
  logic tick_ff;
  logic [CW-1:0] term;
  logic at_end;

  // last count of the running period, 2**code - 1
  assign term = CW'((CW + 1)'(1) << act_ff) - CW'(1);
  assign at_end = (cnt_ff == term);

  // new code taken only at a period boundary: no short or fast period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      act_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= at_end;  // see R24
      if (at_end) begin
        cnt_ff <= '0;
        act_ff <= sel;  // see R24
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end

  assign tick = tick_ff;
  assign act_sel = act_ff;

endmodule

// file: hdl/cksl_top.sv
`timescale 1ns/1ps
// How it works
// R01: unlock flag sets only on a write of the unlock bit alone.
// R02: unlock flag clears four cycles later or on a select write.
// R03: rewriting unlock during its window neither restarts nor clears it.
// R04: select code n divides master clock by 2**n, codes up to 8.
// R05: divided tick drives core and every synchronous peripheral.
// R06: select resets to 0, or to 3 with divide-by-eight fuse programmed.
// R07: any select value up to 8 is accepted in the window, fuse notwithstanding.
// R08: sleep enable plus sleep instruction enters the selected mode.
// R09: on wake, core stalls four cycles past start-up, then resumes.
// R10: register contents survive sleep; reset during sleep restarts.
// R11: idle stops core and flash clocks only; any interrupt wakes.
// R12: entering idle or noise reduction starts a conversion if enabled.
// R13: noise reduction stops peripheral, core and flash clocks.
// R14: noise reduction wakes only on its listed sources.
// R15: power-down stops all clocks; few wake sources.
// R16: external level wake must be held long enough by the source.
// R17: power-down wake waits the fuse-defined start-up delay.
// R18: power-save is power-down plus timer, display and display wake.
// R19: timer wake needs its enable and global interrupt enable.
// R20: power-save stops unused timer oscillator and unused main clock.
// R21: sync clock in power-save goes only to display and timer.
// R22: deeper than idle, external interrupt zero wakes by level only.
// R23: standby keeps oscillator on and wakes within six cycles.
// R24: ratio changes are glitch-free with no faster intermediate period.
// R25: software disables interrupts and writes select within four cycles.
// R26: sleep with enable clear or reserved mode is a no-operation.
// R27: reserved select write keeps ratio but clears the unlock flag.
module cksl_top #(
  parameter int ADDR_W = 8,
  parameter int START_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire logic sleep_exec,
  output logic cpu_stall,
  output logic cpu_resume,
  // fuses, taken at the first edge after reset release
  input wire logic divide_by_eight_fuse,
  input wire logic ext_crystal_sel,
  input wire logic [START_W-1:0] wake_startup_cycles,
  // wake sources
  input wire cksl_pkg::cksl_wake_s wake,
  // converter
  input wire logic converter_enabled,
  output logic conv_start,
  // clock tree
  output logic sys_tick,
  output cksl_pkg::cksl_gate_s gate
);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, read data sampled with pready
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic acc_first;
  logic acc_done;
  logic hit_div;
  logic hit_slp;
  logic hit_stat;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;

  assign acc_first = psel & penable & ~pready_ff;
  assign acc_done = psel & penable & pready_ff;
  assign hit_div = (paddr == ADDR_W'(cksl_pkg::OFS_DIV));
  assign hit_slp = (paddr == ADDR_W'(cksl_pkg::OFS_SLP));
  assign hit_stat = (paddr == ADDR_W'(cksl_pkg::OFS_STAT));
  assign wbyte = pwdata[7:0];

  logic unlock;
  logic [2:0] unl_cnt;
  logic [3:0] div_sel_ff;
  logic [3:0] act_sel;
  logic slp_en_ff;
  logic [2:0] slp_mode_ff;

  // registers are one byte wide in lane 0, upper bits read zero
  always_comb begin
    rd_mux = '0;
    if (hit_div) begin
      rd_mux[cksl_pkg::UNLOCK_BIT] = unlock;
      rd_mux[cksl_pkg::SEL_W-1:0] = div_sel_ff;
    end else if (hit_slp) begin
      rd_mux[cksl_pkg::SLP_EN_BIT] = slp_en_ff;
      rd_mux[cksl_pkg::SLP_MODE_LSB +: cksl_pkg::MODE_W] = slp_mode_ff;
    end else if (hit_stat) begin
      rd_mux[cksl_pkg::SEL_W-1:0] = act_sel;
      rd_mux[cksl_pkg::SEL_W] = (act_sel != div_sel_ff);  // switch pending
    end
  end

  // unmapped addresses answer with pslverr and zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc_first;
      if (acc_first) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_ff <= ~(hit_div | hit_slp | hit_stat);
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  logic wr_div;
  logic wr_slp;
  assign wr_div = acc_done & pwrite & pstrb[0] & hit_div;
  assign wr_slp = acc_done & pwrite & pstrb[0] & hit_slp;

  ////////////////////////////////////////////////////////////////////////////
  // divider change protection
  logic unl_set;
  logic sel_wr;
  logic sel_legal;

  // only the exact unlock pattern opens; a repeat in the window is ignored
  assign unl_set = wr_div & (wbyte == cksl_pkg::UNLOCK_PATTERN) & ~unlock;  // see R01
  assign sel_wr = wr_div & ~wbyte[cksl_pkg::UNLOCK_BIT] & unlock;  // see R02
  assign sel_legal = (wbyte[cksl_pkg::SEL_W-1:0] <= cksl_pkg::SEL_MAX);  // see R04

  // window counter: busy is the unlock flag itself
  cksl_cnt #(.W(3)) u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .load(unl_set),  // see R03
    .clr(sel_wr),  // see R02
    .val(3'(cksl_pkg::UNLOCK_CYCLES)),  // see R02 R25
    .cnt(unl_cnt),
    .busy(unlock)
  );

  // select: constant under reset, fuse value caught at the first edge after
  logic fuse_done_ff;
  logic ext_crystal_ff;
  logic [START_W-1:0] startup_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_done_ff <= 1'b0;
      div_sel_ff <= cksl_pkg::SEL_RESET;
      ext_crystal_ff <= 1'b0;
      startup_ff <= '0;
    end else if (!fuse_done_ff) begin
      fuse_done_ff <= 1'b1;
      div_sel_ff <= divide_by_eight_fuse ? cksl_pkg::SEL_DIV8 : cksl_pkg::SEL_RESET;  // see R06
      ext_crystal_ff <= ext_crystal_sel;
      startup_ff <= wake_startup_cycles;  // see R17
    end else if (sel_wr && sel_legal) begin
      div_sel_ff <= wbyte[cksl_pkg::SEL_W-1:0];  // see R07 R27
    end
  end

  // glitch-free divider; its tick is the system clock enable
  logic div_tick;
  cksl_div #(.SW(cksl_pkg::SEL_W), .CW(8)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .sel(div_sel_ff),  // see R04
    .tick(div_tick),
    .act_sel(act_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sleep control register; contents kept through sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_en_ff <= 1'b0;
      slp_mode_ff <= cksl_pkg::MODE_IDLE;
    end else if (wr_slp) begin
      slp_en_ff <= wbyte[cksl_pkg::SLP_EN_BIT];
      slp_mode_ff <= wbyte[cksl_pkg::SLP_MODE_LSB +: cksl_pkg::MODE_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep sequencer
  cksl_pkg::cksl_state_e state_ff;
  cksl_pkg::cksl_state_e nxt_state;
  logic [2:0] mode_ff;
  logic mode_ok;
  logic enter;
  logic tmr_wake;
  logic wake_hit;
  logic use_async;
  logic use_sync;
  logic wk_load;
  logic [START_W-1:0] wk_val;
  logic [START_W-1:0] wk_cnt;
  logic wk_last;

  // standby needs a crystal; reserved codes never sleep
  always_comb begin
    case (slp_mode_ff)
      cksl_pkg::MODE_IDLE: mode_ok = 1'b1;
      cksl_pkg::MODE_NRM: mode_ok = 1'b1;
      cksl_pkg::MODE_PDOWN: mode_ok = 1'b1;
      cksl_pkg::MODE_PSAVE: mode_ok = 1'b1;
      cksl_pkg::MODE_STBY: mode_ok = ext_crystal_ff;  // see R23
      default: mode_ok = 1'b0;  // see R26
    endcase
  end

  assign enter = sleep_exec & slp_en_ff & mode_ok;  // see R08
  assign tmr_wake = wake.global_ie & ((wake.tmr_ovf & wake.tmr_ovf_ie) |
                                      (wake.tmr_cmp & wake.tmr_cmp_ie));  // see R19
  assign use_async = wake.disp_async | wake.tmr_async;
  assign use_sync = wake.disp_sync | wake.tmr_sync;
  assign wk_last = (wk_cnt == START_W'(1));

  // wake sources narrow with depth; edge form of external_interrupt_zero only wakes idle
  always_comb begin
    case (mode_ff)
      cksl_pkg::MODE_IDLE: wake_hit = wake.external_interrupt_zero_level | wake.external_interrupt_zero_edge | wake.pin_change |
                                      wake.serial_start | wake.display_irq | tmr_wake |
                                      wake.store_ready | wake.conv_done |
                                      wake.other_irq;  // see R11
      cksl_pkg::MODE_NRM: wake_hit = wake.conv_done | wake.display_irq | wake.serial_start |
                                     tmr_wake | wake.store_ready | wake.external_interrupt_zero_level |
                                     wake.pin_change;  // see R14
      cksl_pkg::MODE_PSAVE: wake_hit = wake.serial_start | wake.external_interrupt_zero_level | wake.pin_change |
                                       wake.display_irq | tmr_wake;  // see R18
      default: wake_hit = wake.serial_start | wake.external_interrupt_zero_level |
                          wake.pin_change;  // see R15 R22
    endcase
  end

  // sleep, start-up wait in power-down, power-save and standby, four-cycle halt, then back to running
  always_comb begin
    nxt_state = state_ff;
    wk_load = 1'b0;
    wk_val = '0;
    case (state_ff)
      cksl_pkg::ST_ACTIVE: begin
        if (enter) begin
          nxt_state = cksl_pkg::ST_SLEEP;
        end
      end
      cksl_pkg::ST_SLEEP: begin
        if (wake_hit) begin
          wk_load = 1'b1;
          if (mode_ff == cksl_pkg::MODE_PDOWN || mode_ff == cksl_pkg::MODE_PSAVE) begin
            nxt_state = cksl_pkg::ST_START;
            wk_val = (startup_ff == '0) ? START_W'(1) : startup_ff;  // see R17
          end else if (mode_ff == cksl_pkg::MODE_STBY) begin
            nxt_state = cksl_pkg::ST_START;
            wk_val = START_W'(cksl_pkg::STBY_CYCLES);  // see R23
          end else begin
            nxt_state = cksl_pkg::ST_HALT;
            wk_val = START_W'(cksl_pkg::HALT_CYCLES);  // see R09
          end
        end
      end
      cksl_pkg::ST_START: begin
        if (wk_last) begin
          nxt_state = cksl_pkg::ST_HALT;
          wk_load = 1'b1;
          wk_val = START_W'(cksl_pkg::HALT_CYCLES);  // see R09
        end
      end
      cksl_pkg::ST_HALT: begin
        if (wk_last) begin
          nxt_state = cksl_pkg::ST_ACTIVE;
        end
      end
      default: nxt_state = cksl_pkg::ST_ACTIVE;
    endcase
  end

  cksl_cnt #(.W(START_W)) u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .load(wk_load),
    .clr(1'b0),
    .val(wk_val),
    .cnt(wk_cnt),
    .busy()
  );

  // only presetn clears state, so reset during sleep restarts the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= cksl_pkg::ST_ACTIVE;  // see R10
      mode_ff <= cksl_pkg::MODE_IDLE;
    end else begin
      state_ff <= nxt_state;
      if (enter && state_ff == cksl_pkg::ST_ACTIVE) begin
        mode_ff <= slp_mode_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock domain enables per state and mode
  cksl_pkg::cksl_gate_s nxt_gate;
  cksl_pkg::cksl_gate_s gate_ff;
  always_comb begin
    nxt_gate = '0;
    nxt_gate.timer_osc = use_async;
    if (nxt_state == cksl_pkg::ST_ACTIVE || nxt_state == cksl_pkg::ST_HALT) begin
      nxt_gate = '1;
      nxt_gate.timer_osc = use_async;
      nxt_gate.ps_sync = 1'b0;
    end else begin
      case (nxt_state == cksl_pkg::ST_SLEEP && state_ff == cksl_pkg::ST_ACTIVE ?
            slp_mode_ff : mode_ff)
        cksl_pkg::MODE_IDLE: begin
          nxt_gate.periph = 1'b1;  // see R11
          nxt_gate.conv = 1'b1;
          nxt_gate.async_clk = 1'b1;
          nxt_gate.main_osc = 1'b1;
        end
        cksl_pkg::MODE_NRM: begin
          nxt_gate.conv = 1'b1;  // see R13
          nxt_gate.async_clk = 1'b1;
          nxt_gate.main_osc = 1'b1;
        end
        cksl_pkg::MODE_PSAVE: begin
          nxt_gate.async_clk = use_async;  // see R18
          nxt_gate.main_osc = use_sync;  // see R20
          nxt_gate.ps_sync = use_sync;  // see R21
        end
        cksl_pkg::MODE_STBY: begin
          nxt_gate.timer_osc = 1'b0;
          nxt_gate.main_osc = 1'b1;  // see R23
        end
        default: begin
          nxt_gate.timer_osc = 1'b0;  // see R15
        end
      endcase
      if (nxt_state == cksl_pkg::ST_START) begin
        nxt_gate.main_osc = 1'b1;  // oscillator restarts during the wait
      end
    end
  end

  // registered outputs toward core, converter and clock tree
  logic stall_ff;
  logic resume_ff;
  logic conv_start_ff;
  logic tick_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_ff <= '1;
      stall_ff <= 1'b0;
      resume_ff <= 1'b0;
      conv_start_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      gate_ff <= nxt_gate;
      tick_ff <= div_tick;  // see R05
      stall_ff <= (nxt_state != cksl_pkg::ST_ACTIVE);  // see R09
      resume_ff <= (state_ff == cksl_pkg::ST_HALT) && (nxt_state == cksl_pkg::ST_ACTIVE);
      conv_start_ff <= enter && (state_ff == cksl_pkg::ST_ACTIVE) && converter_enabled &&
                       (slp_mode_ff == cksl_pkg::MODE_IDLE ||
                        slp_mode_ff == cksl_pkg::MODE_NRM);  // see R12
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu_stall = stall_ff;
  assign cpu_resume = resume_ff;
  assign conv_start = conv_start_ff;
  assign sys_tick = tick_ff;
  assign gate = gate_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_unlock_set;
    (wr_div && wbyte == cksl_pkg::UNLOCK_PATTERN && !unlock) |=> unlock ##3 unlock ##1 !unlock;
  endproperty
  a_unlock_set: assert property (p_unlock_set) // see R01
    else $error("unlock flag not open for four cycles");

  property p_unlock_drop;
    $rose(unlock) |-> ##[1:4] !unlock;
  endproperty
  a_unlock_drop: assert property (p_unlock_drop) // see R02
    else $error("unlock flag outlived its window");

  property p_unlock_keep;
    (unlock && wr_div && wbyte == cksl_pkg::UNLOCK_PATTERN) |=>
      (unl_cnt == $past(unl_cnt) - 3'd1 && unlock == (unl_cnt != 3'd0));
  endproperty
  a_unlock_keep: assert property (p_unlock_keep) // see R03
    else $error("unlock rewrite changed the window");

  property p_sel_reserved;
    (sel_wr && !sel_legal) |=> ($stable(div_sel_ff) && !unlock);
  endproperty
  a_sel_reserved: assert property (p_sel_reserved) // see R27
    else $error("reserved select changed ratio or kept unlock");

  property p_sel_locked;
    (wr_div && !unlock) |=> $stable(div_sel_ff);
  endproperty
  a_sel_locked: assert property (p_sel_locked) // see R07
    else $error("select changed without unlock");

  property p_noop_sleep;
    (state_ff == cksl_pkg::ST_ACTIVE && sleep_exec && !(slp_en_ff && mode_ok)) |=>
      (state_ff == cksl_pkg::ST_ACTIVE && gate.core);
  endproperty
  a_noop_sleep: assert property (p_noop_sleep) // see R26
    else $error("sleep taken while disabled or reserved");

  property p_idle_gates;
    (state_ff == cksl_pkg::ST_SLEEP && mode_ff == cksl_pkg::MODE_IDLE && !wake_hit) |=>
      (!gate.core && !gate.flash && gate.periph && gate.conv && gate.async_clk);
  endproperty
  a_idle_gates: assert property (p_idle_gates) // see R11
    else $error("idle clock gating wrong");

  property p_pdown_gates;
    (state_ff == cksl_pkg::ST_SLEEP && mode_ff == cksl_pkg::MODE_PDOWN && !wake_hit) |=>
      (gate == '0);
  endproperty
  a_pdown_gates: assert property (p_pdown_gates) // see R15
    else $error("power-down left a clock running");

  property p_halt_four;
    $rose(state_ff == cksl_pkg::ST_HALT) |->
      (state_ff == cksl_pkg::ST_HALT && cpu_stall) [*4] ##1 (state_ff == cksl_pkg::ST_ACTIVE);
  endproperty
  a_halt_four: assert property (p_halt_four) // see R09
    else $error("halt after wake not four cycles");

  property p_stby_six;
    (state_ff == cksl_pkg::ST_SLEEP && mode_ff == cksl_pkg::MODE_STBY && wake_hit) |=>
      (state_ff == cksl_pkg::ST_START && gate.main_osc) [*6] ##1 (state_ff == cksl_pkg::ST_HALT);
  endproperty
  a_stby_six: assert property (p_stby_six) // see R23
    else $error("standby wake not six cycles");

  property p_edge_deep;
    (state_ff == cksl_pkg::ST_SLEEP && mode_ff != cksl_pkg::MODE_IDLE && !wake_hit &&
      wake.external_interrupt_zero_edge) |=> (state_ff == cksl_pkg::ST_SLEEP);
  endproperty
  a_edge_deep: assert property (p_edge_deep) // see R22
    else $error("edge interrupt woke a deep sleep");

endmodule

// file: shared/cksl_pkg.sv
package cksl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the apb bus
  localparam logic [7:0] OFS_DIV = 8'h00;  // clock_divider_control
  localparam logic [7:0] OFS_SLP = 8'h04;  // sleep_control_register
  localparam logic [7:0] OFS_STAT = 8'h08;  // read-only status

  // clock_divider_control fields
  localparam int UNLOCK_BIT = 7;
  localparam int SEL_W = 4;
  localparam logic [7:0] UNLOCK_PATTERN = 8'h80;
  localparam logic [3:0] SEL_MAX = 4'h8;  // ratio 256
  localparam logic [3:0] SEL_RESET = 4'h0;  // fuse unprogrammed
  localparam logic [3:0] SEL_DIV8 = 4'h3;  // fuse programmed

  // sleep_control_register fields
  localparam int SLP_EN_BIT = 0;
  localparam int SLP_MODE_LSB = 1;
  localparam int MODE_W = 3;

  // sleep_mode_select codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NRM = 3'h1;  // converter_noise_reduction_mode
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STBY = 3'h6;

  // timing counts in master clock cycles
  localparam int UNLOCK_CYCLES = 4;
  localparam int HALT_CYCLES = 4;
  localparam int STBY_CYCLES = 6;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_START,
    ST_HALT
  } cksl_state_e;

  // wake sources and clocking of the display controller and async timer
  typedef struct packed {
    logic external_interrupt_zero_level;
    logic external_interrupt_zero_edge;
    logic pin_change;
    logic serial_start;
    logic display_irq;
    logic tmr_ovf;
    logic tmr_cmp;
    logic tmr_ovf_ie;   // async_timer_interrupt_mask overflow enable
    logic tmr_cmp_ie;   // async_timer_interrupt_mask compare enable
    logic global_ie;    // from processor_flags_word
    logic store_ready;
    logic conv_done;
    logic other_irq;
    logic disp_async;
    logic disp_sync;
    logic tmr_async;
    logic tmr_sync;
  } cksl_wake_s;

  // clock domain enables, high while the domain runs
  typedef struct packed {
    logic core;
    logic flash;
    logic periph;
    logic conv;
    logic async_clk;
    logic main_osc;
    logic timer_osc;
    logic ps_sync;  // sync clock to display and async timer only
  } cksl_gate_s;

endpackage

// file: sim/cksl_cpu_model.sv
`timescale 1ns/1ps
// core stand-in: one sleep opcode per request, counts resumes
module cksl_cpu_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench request and core side
  input wire logic go,
  input wire logic cpu_resume,
  output logic sleep_exec,
  output logic [7:0] n_resume
);
  logic exec_ff;
  logic [7:0] res_ff;
  assign sleep_exec = exec_ff;
  assign n_resume = res_ff;
  // single-cycle pulse, the core cannot issue two sleeps back to back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) exec_ff <= 1'b0;
    else exec_ff <= go & ~exec_ff;
  end
  // resume count lets the bench see the return after the handler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) res_ff <= 8'h00;
    else if (cpu_resume) res_ff <= res_ff + 8'h01;
  end
endmodule

// file: sim/clock_divider_and_sleep_gating_tb_top.sv
`timescale 1ns/1ps
module clock_divider_and_sleep_gating_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, cen = 0;
  logic f8 = 0, xt = 0;
  logic [7:0] paddr = 0, nres;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, sx, stall, resume, cs, tick;
  cksl_pkg::cksl_wake_s wake = '0;
  cksl_pkg::cksl_gate_s gate;
  int fail_count = 0, num_checks = 0, cyc = 0, n;
  always #50 pclk = ~pclk;
  cksl_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sx), .cpu_stall(stall),
    .cpu_resume(resume), .divide_by_eight_fuse(f8), .ext_crystal_sel(xt),
    .wake_startup_cycles(16'h0003), .wake(wake), .converter_enabled(cen),
    .conv_start(cs), .sys_tick(tick), .gate(gate));
  cksl_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .go(go), .cpu_resume(resume),
    .sleep_exec(sx), .n_resume(nres));
  ////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, all tests need well under 2000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      print_verdict;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // apb transfer; request held until the edge that sees pready, data taken there
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task fire;
    @(posedge pclk) go <= 1;
    @(posedge pclk) go <= 0;
    repeat (3) @(negedge pclk);
  endtask
  // cycles from the wake request until the resume pulse, bounded
  task count_resume;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (resume !== 1'b1 && n < 50);
  endtask
  task t_reg;
    apb(0, 8'h00, 0); chk(rd, 32'h0);
    apb(1, 8'h00, 32'h81); apb(0, 8'h00, 0); chk(rd, 32'h0);
    apb(0, 8'h0C, 0); chk(er, 1'b1);
    fire;
    chk(stall, 1'b0);
    $display("test reg done");
  endtask
  task t_div;
    apb(1, 8'h00, 32'h80); apb(0, 8'h00, 0); chk(rd, 32'h80);
    apb(0, 8'h00, 0); chk(rd, 32'h0);
    apb(1, 8'h00, 32'h80); apb(1, 8'h00, 32'h80);
    apb(0, 8'h00, 0); chk(rd, 32'h0);
    apb(1, 8'h00, 32'h80); apb(1, 8'h00, 32'h05);
    apb(0, 8'h00, 0); chk(rd, 32'h05);
    repeat (40) @(posedge pclk);
    n = 0;
    repeat (64) begin
      @(negedge pclk);
      n += tick;
    end
    chk(n, 2);
    apb(1, 8'h00, 32'h80); apb(1, 8'h00, 32'h09);
    apb(0, 8'h00, 0); chk(rd, 32'h05);
    $display("test div done");
  endtask
  task t_idle;
    cen <= 1;
    apb(1, 8'h04, 32'h01);
    fire;
    chk({gate.core, gate.flash, gate.periph, gate.conv}, 4'h3);
    @(posedge pclk) wake.other_irq <= 1;
    count_resume;
    chk(n, 6);
    @(posedge pclk) wake.other_irq <= 0;
    $display("test idle done");
  endtask
  task t_pdown;
    apb(1, 8'h04, 32'h05);
    fire;
    chk(gate, 8'h00);
    @(posedge pclk) wake.external_interrupt_zero_edge <= 1;
    repeat (10) @(negedge pclk);
    chk(stall, 1'b1);
    @(posedge pclk) wake.external_interrupt_zero_level <= 1;
    repeat (20) @(negedge pclk);
    chk(nres, 8'h02);
    @(posedge pclk) wake <= '0;
    $display("test pdown done");
  endtask
  // reset while in power-down, fuses now programmed, then standby and its wake
  task t_sby;
    fire;
    @(posedge pclk) presetn <= 0;
    f8 <= 1;
    xt <= 1;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    chk(stall, 1'b0);
    apb(0, 8'h00, 0); chk(rd, 32'h03);
    apb(1, 8'h04, 32'h0D);
    fire;
    chk(gate, 8'h04);
    @(posedge pclk) wake.external_interrupt_zero_level <= 1;
    count_resume;
    chk(n, 12);
    @(posedge pclk) wake <= '0;
    $display("test standby done");
  endtask
  // conversion start pulses counted over the whole run
  int nconv = 0;
  always @(negedge pclk) nconv += cs;
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    t_reg;
    t_div;
    t_idle;
    chk(nconv, 1);
    t_pdown;
    t_sby;
    print_verdict;
  end
endmodule
